/* slw_burst_addr.sv */
// two-bit burst address generator with linear and interleaved order
// assumes load, step and hold come from the owning control on the same clock
`timescale 1ns/100ps
`include "slw_map.svh"

module slw_burst_addr #(
    parameter int BURST_W = `SLW_BURST_W
) (
    input wire logic i_clock,                 // system clock
    input wire logic i_sys_rst,               // async reset, active high
    input wire logic i_hold,                  // stall, keep state
    input wire logic i_load,                  // fresh start address
    input wire logic i_step,                  // burst continue cycle
    input wire logic i_interleave,            // interleaved order
    input wire logic [BURST_W-1:0] i_start,   // external low address bits
    output logic [BURST_W-1:0] o_low          // low address for this cycle
);

    logic [BURST_W-1:0] start_reg;
    logic [BURST_W-1:0] start_next;
    logic [BURST_W-1:0] cnt_reg;
    logic [BURST_W-1:0] cnt_next;

    always_comb begin
        start_next = start_reg;
        cnt_next = cnt_reg;
        if (!i_hold) begin
            if (i_load) begin
                start_next = i_start;
                cnt_next = '0;
            end else if (i_step) begin
                cnt_next = BURST_W'(cnt_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            start_reg <= '0;
            cnt_reg <= '0;
        end else begin
            start_reg <= start_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_low = i_interleave ? (start_next ^ cnt_next) : BURST_W'(start_next + cnt_next);

    // ****************************************
    // checks
    // ****************************************
    AST_BURST_CNT: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (!i_hold && !i_load && i_step) |=> (cnt_reg == BURST_W'($past(cnt_reg) + 1'b1)))
        else $error("burst counter did not advance");

    AST_BURST_WRAP: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (!i_hold && i_load) ##1 (!i_hold && !i_load && i_step)[*4] |=> (cnt_reg == '0))
        else $error("burst counter did not wrap after four");

endmodule

/* slw_ctrl.sv */
// command decode, late-write pipeline and output control of a late-write sram
// assumes commands synchronous to i_clock; mode, order, sleep and oe pins are async
//
// Functional notes
// - clock gate high freezes command, burst and pipeline state; pin sync and sleep entry run on
// - inputs sampled on edge, except oe/order/sleep/pipe select
// - all three selects active, else deselect
// - each low lane strobe writes its byte
// - write with no lane strobe is abort
// - read loads address on selected load edge
// - pipelined read data two cycles after command
// - flow-through read one cycle shorter
// - continue uses counter, ignores selects and direction
// - two-bit counter steps on each continue
// - oe high gives dummy read, no drive
// - drivers forced off for write cycles
// - deselect continue keeps outputs undriven
// - stall keeps read driven, write undriven
// - outputs undriven from reset until read
// - sleep two cycles after request, state kept
// - linear or interleaved order, wraps at four
// - pipe select low chooses flow-through
`timescale 1ns/100ps
`include "slw_map.svh"

module slw_ctrl import slw_pkg::*; #(
    parameter int ADDR_W = `SLW_ADDR_W,
    parameter int LANES = `SLW_LANES,
    parameter int LANE_W = `SLW_LANE_W
) (
    input wire logic i_clock,                      // system clock, 10 MHz
    input wire logic i_sys_rst,                    // async reset, active high
    input wire logic i_clock_gate_n,               // high ignores the edge
    input wire logic i_chip_select_1_n,            // select, active low
    input wire logic i_chip_select_2,              // select, active high
    input wire logic i_chip_select_3_n,            // select, active low
    input wire logic i_store_select_n,             // low writes, high reads
    input wire logic i_lane_a_store_n,             // lane 0 write strobe
    input wire logic i_lane_b_store_n,             // lane 1 write strobe
    input wire logic i_lane_c_store_n,             // lane 2 write strobe
    input wire logic i_lane_d_store_n,             // lane 3 write strobe
    input wire logic i_burst_step,                 // high continues burst
    input wire logic [ADDR_W-1:0] i_addr,          // external address
    input wire logic [LANES*LANE_W-1:0] i_data_pins, // data pins, input side
    input wire logic i_output_drive_on_n,          // async output enable
    input wire logic i_linear_order_n,             // async, low linear
    input wire logic i_sleep_request,              // async sleep request
    input wire logic i_pipe_select_n,              // async, low flow-through
    output logic [LANES*LANE_W-1:0] o_data_pins,   // data pins, output side
    output logic o_data_oe,                        // high while driving data
    output logic o_sleep_active                    // device asleep
);

    localparam int BURST_W = `SLW_BURST_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int DATA_W = LANES * LANE_W;

    // ****************************************
    // async pin conditioning
    // ****************************************
    logic [`SLW_ASYNC_W-1:0] as_s1_reg;
    logic [`SLW_ASYNC_W-1:0] as_s2_reg;
    logic [`SLW_ASYNC_W-1:0] as_s3_reg;
    logic [`SLW_ASYNC_W-1:0] as_f_reg;
    logic [`SLW_ASYNC_W-1:0] as_raw;

    assign as_raw = {i_pipe_select_n, i_sleep_request, i_linear_order_n, i_output_drive_on_n};

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            as_s1_reg <= `SLW_ASYNC_RST;
            as_s2_reg <= `SLW_ASYNC_RST;
            as_s3_reg <= `SLW_ASYNC_RST;
            as_f_reg <= `SLW_ASYNC_RST;
        end else begin
            as_s1_reg <= as_raw;
            as_s2_reg <= as_s1_reg;
            as_s3_reg <= as_s2_reg;
            // a bit moves only when stages two and three agree
            as_f_reg <= (as_s2_reg & as_s3_reg) | (as_f_reg & (as_s2_reg | as_s3_reg));
        end
    end

    logic oe_off;
    logic interleave;
    logic sleep_req_f;
    logic flow_mode;

    assign oe_off = as_f_reg[`SLW_AS_OE_N];
    assign interleave = as_f_reg[`SLW_AS_LIN_N];
    assign sleep_req_f = as_f_reg[`SLW_AS_SLEEP];
    assign flow_mode = !as_f_reg[`SLW_AS_PIPE_N];

    // ****************************************
    // sleep entry
    // ****************************************
    logic [`SLW_SLEEP_CYC-1:0] sleep_sh_reg;
    logic sleep_on;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sleep_sh_reg <= '0;
        end else begin
            // dropping the request wakes at once; recovery is the controller's job
            sleep_sh_reg <= sleep_req_f ? {sleep_sh_reg[`SLW_SLEEP_CYC-2:0], 1'b1} : '0;
        end
    end

    assign sleep_on = sleep_sh_reg[`SLW_SLEEP_CYC-1];
    assign o_sleep_active = sleep_on;

    // ****************************************
    // command decode
    // ****************************************
    slw_kind_t kind_reg;
    slw_kind_t kind_next;
    logic go;
    logic load;
    logic selected;
    logic cmd_read;
    logic cmd_write;
    logic [LANES-1:0] lanes_act;
    logic [ADDR_W-BURST_W-1:0] hi_reg;
    logic [BURST_W-1:0] low_addr;
    logic [ADDR_W-1:0] cmd_addr;

    assign go = !i_clock_gate_n && !sleep_on;
    assign load = !i_burst_step;
    assign selected = !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
    assign lanes_act = ~{i_lane_d_store_n, i_lane_c_store_n, i_lane_b_store_n, i_lane_a_store_n};

    always_comb begin
        kind_next = kind_reg;
        if (load) begin
            if (!selected) begin
                kind_next = KIND_IDLE;
            end else if (i_store_select_n) begin
                kind_next = KIND_READ;
            end else begin
                kind_next = KIND_WRITE;
            end
        end
    end

    always_comb begin
        cmd_read = 1'b0;
        cmd_write = 1'b0;
        case (kind_next)
            KIND_READ: begin
                cmd_read = go;
            end
            KIND_WRITE: begin
                cmd_write = go;
            end
            KIND_IDLE: begin
                cmd_read = 1'b0;
            end
            default: begin
                cmd_write = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            kind_reg <= KIND_IDLE;
            hi_reg <= '0;
        end else if (go) begin
            kind_reg <= kind_next;
            if (load && selected) begin
                hi_reg <= i_addr[ADDR_W-1:BURST_W];
            end
        end
    end

    slw_burst_addr #(
        .BURST_W(BURST_W)
    ) u_burst (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_hold(!go),
        .i_load(load && selected),
        .i_step(i_burst_step),
        .i_interleave(interleave),
        .i_start(i_addr[BURST_W-1:0]),
        .o_low(low_addr)
    );

    assign cmd_addr = {(load ? i_addr[ADDR_W-1:BURST_W] : hi_reg), low_addr};

    // ****************************************
    // late-write pipeline
    // ****************************************
    logic w1_vld_reg;
    logic w2_vld_reg;
    logic [LANES-1:0] w1_lanes_reg;
    logic [LANES-1:0] w2_lanes_reg;
    logic [ADDR_W-1:0] w1_addr_reg;
    logic [ADDR_W-1:0] w2_addr_reg;
    logic wr_fire;
    logic [LANES-1:0] wr_lanes;
    logic [ADDR_W-1:0] wr_addr;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            w1_vld_reg <= 1'b0;
            w2_vld_reg <= 1'b0;
            w1_lanes_reg <= '0;
            w2_lanes_reg <= '0;
            w1_addr_reg <= '0;
            w2_addr_reg <= '0;
        end else if (go) begin
            w1_vld_reg <= cmd_write && (|lanes_act);
            w1_lanes_reg <= cmd_write ? lanes_act : '0;
            w1_addr_reg <= cmd_addr;
            w2_vld_reg <= w1_vld_reg;
            w2_lanes_reg <= w1_lanes_reg;
            w2_addr_reg <= w1_addr_reg;
        end
    end

    assign wr_fire = go && (flow_mode ? w1_vld_reg : w2_vld_reg);
    assign wr_lanes = flow_mode ? w1_lanes_reg : w2_lanes_reg;
    assign wr_addr = flow_mode ? w1_addr_reg : w2_addr_reg;

    // ****************************************
    // storage
    // ****************************************
    logic [DATA_W-1:0] rd_word;

    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] mem [0:DEPTH-1];
            always_ff @(posedge i_clock) begin
                if (wr_fire && wr_lanes[g]) begin
                    mem[wr_addr] <= i_data_pins[g*LANE_W +: LANE_W];
                end
            end
            assign rd_word[g*LANE_W +: LANE_W] = mem[cmd_addr];
        end
    endgenerate

    // ****************************************
    // read path and output drive
    // ****************************************
    logic p1_rd_reg;
    logic [DATA_W-1:0] p1_data_reg;
    logic own_reg;
    logic own_next;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            p1_rd_reg <= 1'b0;
            p1_data_reg <= '0;
        end else if (go) begin
            p1_rd_reg <= cmd_read;
            p1_data_reg <= rd_word;
        end
    end

    assign own_next = go ? (flow_mode ? cmd_read : p1_rd_reg) : own_reg;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            own_reg <= 1'b0;
            o_data_pins <= '0;
        end else begin
            own_reg <= own_next;
            if (go) begin
                o_data_pins <= flow_mode ? rd_word : p1_data_reg;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= own_next && !oe_off && !sleep_on;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    AST_STALL_HOLD: assert property (
        i_clock_gate_n |=> ($stable(own_reg) && $stable(o_data_pins) && $stable(w1_vld_reg)))
        else $error("state moved on a gated edge");

    AST_DESELECT: assert property (
        (go && load && !selected) |-> (!cmd_read && !cmd_write))
        else $error("deselected load started an access");

    AST_LANES: assert property (
        cmd_write |=> (w1_lanes_reg == $past(lanes_act)))
        else $error("lane enables not captured");

    AST_ABORT: assert property (
        (cmd_write && lanes_act == '0) |=> !w1_vld_reg)
        else $error("write abort queued a write");

    AST_PIPE_LAT: assert property (
        (!flow_mode && cmd_read && !oe_off) ##1 (go && !oe_off && !flow_mode) |=> o_data_oe)
        else $error("pipelined read not driven two cycles on");

    AST_FLOW_LAT: assert property (
        (flow_mode && cmd_read && !oe_off) |=> (o_data_oe && o_data_pins == $past(rd_word)))
        else $error("flow-through read not driven next cycle");

    AST_OE_OFF: assert property (
        oe_off |=> !o_data_oe)
        else $error("driving with output enable off");

    AST_WRITE_OFF: assert property (
        (flow_mode && cmd_write) |=> !o_data_oe)
        else $error("driving during a write cycle");

    AST_DESEL_CONT: assert property (
        (flow_mode && go && i_burst_step && kind_reg == KIND_IDLE) |=> !o_data_oe)
        else $error("deselect continue drove the bus");

    AST_STALL_READ: assert property (
        (o_data_oe && i_clock_gate_n && !oe_off && !sleep_on) |=> o_data_oe)
        else $error("bus released during a read stall");

    AST_SLEEP: assert property (
        ($rose(sleep_req_f) ##1 sleep_req_f) |=> (sleep_on ##1 !o_data_oe))
        else $error("sleep not entered after two cycles");

    COV_PIPE_READ: cover property (!flow_mode && cmd_read ##2 o_data_oe);
    COV_FLOW_READ: cover property (flow_mode && cmd_read ##1 o_data_oe);
    COV_WRITE: cover property (cmd_write ##[1:2] wr_fire);
    COV_BURST: cover property (cmd_read && load ##1 (go && i_burst_step)[*3]);
    COV_STALL: cover property (o_data_oe && i_clock_gate_n);

endmodule

/* slw_host_model.sv */
// memory controller model driving the late-write sram command port
// assumes the bench calls issue or stall once per rising edge, never idles
`timescale 1ns/100ps

module slw_host_model #(
    parameter int ADDR_W = 6,
    parameter int DW = 36
) (
    input wire logic i_clock,             // system clock
    input wire logic i_pipe,              // pipelined mode in use
    input wire logic [DW-1:0] i_dev_data, // device data, output side
    input wire logic i_dev_oe,            // device drives the wire
    output logic o_clock_gate_n,          // high stalls the edge
    output logic [2:0] o_sel,             // select_1_n, select_2, select_3_n
    output logic o_store_select_n,        // low writes
    output logic [3:0] o_lanes_n,         // lane strobes, lane a in bit 0
    output logic o_burst_step,            // high continues
    output logic [ADDR_W-1:0] o_addr,     // external address
    output logic [DW-1:0] o_wire          // resolved data wire
);
    logic cur_wr = 1'b0;
    logic stage_wr = 1'b0;
    logic drv_en = 1'b0;
    logic [DW-1:0] cur_d = '0;
    logic [DW-1:0] stage_d = '0;
    logic [DW-1:0] drv_d = '0;
    logic [DW-1:0] junk = 36'h5A3C96E1F;

    initial begin
        o_clock_gate_n = 1'b0;
        o_sel = 3'b110;
        o_store_select_n = 1'b1;
        o_lanes_n = 4'hF;
        o_burst_step = 1'b0;
        o_addr = '0;
    end

    // driven just after the edge, loads carry a fresh address
    task automatic issue(input logic [2:0] sel, input logic st_n, input logic [3:0] ln,
                         input logic stp, input logic [ADDR_W-1:0] a, input logic has_d,
                         input logic [DW-1:0] d);
        @(posedge i_clock);
        o_clock_gate_n <= 1'b0;
        o_sel <= sel;
        o_store_select_n <= st_n;
        o_lanes_n <= ln;
        o_burst_step <= stp;
        o_addr <= a;
        cur_wr <= has_d;
        cur_d <= d;
    endtask

    task automatic stall(input int n);
        repeat (n) begin
            @(posedge i_clock);
            o_clock_gate_n <= 1'b1;
        end
    endtask

    // write data at third or second unstalled edge
    always @(posedge i_clock) begin
        junk <= {junk[DW-2:0], ~junk[DW-1]};
        if (o_clock_gate_n == 1'b0) begin
            stage_wr <= cur_wr;
            stage_d <= cur_d;
            drv_en <= i_pipe ? stage_wr : cur_wr;
            drv_d <= i_pipe ? stage_d : cur_d;
        end
    end

    // released wire keeps no value, contention shows unknown
    assign o_wire = (drv_en && i_dev_oe) ? 'x : drv_en ? drv_d : i_dev_oe ? i_dev_data : junk;
endmodule

/* slw_map.svh */
// constants for the late-write sram control block
// assumes inclusion by bare name from the design modules
`ifndef SLW_MAP_SVH
`define SLW_MAP_SVH

// ****************************************
// data organisation
// ****************************************
`define SLW_LANES 4
`define SLW_LANE_W 9
`define SLW_ADDR_W 18
`define SLW_BURST_W 2

// ****************************************
// asynchronous pin vector layout
// ****************************************
`define SLW_ASYNC_W 4
`define SLW_AS_OE_N 0
`define SLW_AS_LIN_N 1
`define SLW_AS_SLEEP 2
`define SLW_AS_PIPE_N 3
// drivers off, linear, awake, pipelined
`define SLW_ASYNC_RST 4'h9

// ****************************************
// timing
// ****************************************
`define SLW_SLEEP_CYC 2

`endif

/* slw_pkg.sv */
// types shared by the late-write sram control block
// assumes slw_map.svh is reachable on the include path
package slw_pkg;

    // ****************************************
    // burst kind carried between load and continue cycles
    // ****************************************
    typedef enum logic [1:0] {
        KIND_IDLE  = 2'b00,
        KIND_READ  = 2'b01,
        KIND_WRITE = 2'b10
    } slw_kind_t;

endpackage

/* testbench.sv */
// self-checking bench for the late-write sram control block
// assumes slw_host_model drives commands; a queue-free reference runs beside it
`timescale 1ns/100ps

module testbench;
    localparam logic [2:0] SEL = 3'b010;
    logic i_clock, i_sys_rst, oe_n, lin_n, sleep, pipe_n, gate_n, st_n, step;
    logic sleep_act, dev_oe;
    logic e_v = 1'b0;
    logic s_v = 1'b0;
    logic x_v = 1'b0;
    logic [2:0] sel;
    logic [3:0] lanes;
    logic [5:0] addr;
    logic [35:0] wire_d, dev_d, e_d, s_d, x_d;
    logic [35:0] mem_m [64];
    logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
    int fail_count = 0;
    int n_tests = 0;
    int kind_m = 0;
    int base = 0;
    int cnt = 0;
    int seed, a, w;

    slw_ctrl #(.ADDR_W(6)) slw_ctrl_inst (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clock_gate_n(gate_n),
        .i_chip_select_1_n(sel[2]), .i_chip_select_2(sel[1]), .i_chip_select_3_n(sel[0]),
        .i_store_select_n(st_n), .i_lane_a_store_n(lanes[0]), .i_lane_b_store_n(lanes[1]),
        .i_lane_c_store_n(lanes[2]), .i_lane_d_store_n(lanes[3]), .i_burst_step(step),
        .i_addr(addr), .i_data_pins(wire_d), .i_output_drive_on_n(oe_n),
        .i_linear_order_n(lin_n), .i_sleep_request(sleep), .i_pipe_select_n(pipe_n),
        .o_data_pins(dev_d), .o_data_oe(dev_oe), .o_sleep_active(sleep_act));

    slw_host_model #(.ADDR_W(6), .DW(36)) slw_host_model_inst (
        .i_clock(i_clock), .i_pipe(pipe_n), .i_dev_data(dev_d), .i_dev_oe(dev_oe),
        .o_clock_gate_n(gate_n), .o_sel(sel), .o_store_select_n(st_n), .o_lanes_n(lanes),
        .o_burst_step(step), .o_addr(addr), .o_wire(wire_d));

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic op(input logic stp, input int kind, input int ad, input logic [3:0] ln,
                      input logic [2:0] cs);
        logic [35:0] d;
        int ea;
        d = 36'({$urandom(), $urandom()});
        // load decides kind, continue keeps it
        if (!stp) begin
            kind_m = (cs == SEL) ? kind : 0;
            base = ad % 64;
            cnt = 0;
        end else begin
            cnt = (cnt + 1) % 4;
        end
        ea = (base & 60) | (lin_n ? ((base ^ cnt) & 3) : ((base + cnt) % 4));
        for (int i = 0; i < 4; i++) begin
            if (kind_m == 2 && !ln[i]) mem_m[ea][9*i +: 9] = d[9*i +: 9];
        end
        slw_host_model_inst.issue(stp ? 3'($urandom()) : cs, stp ? 1'($urandom()) : (kind != 2),
                                  ln, stp, 6'(ad), kind_m == 2, d);
        e_v <= (kind_m == 1) && !oe_n;
        e_d <= mem_m[ea];
    endtask

    task automatic gap(input int n);
        repeat (n) op(1'b0, 0, 0, 4'hF, 3'b110);
    endtask

    task automatic done(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    // output slot one edge later when pipelined
    always @(posedge i_clock) begin
        if (gate_n == 1'b0) begin
            s_v <= e_v;
            s_d <= e_d;
            x_v <= pipe_n ? s_v : e_v;
            x_d <= pipe_n ? s_d : e_d;
        end
        #1;
        check(36'(dev_oe), 36'(x_v));
        if (x_v) check(dev_d, x_d);
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        $display("mismatch at %0t: run timed out", $time);
        end_sim();
    end

    initial begin
        i_sys_rst = 1'b1;
        oe_n = 1'b0;
        lin_n = 1'b0;
        sleep = 1'b0;
        pipe_n = 1'b1;
        seed = $urandom(32'hE624);
        repeat (10) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        gap(6);
        for (int md = 0; md < 4; md++) begin
            pipe_n <= 1'((md >> 1) + (seed >> 1));
            lin_n <= 1'(md + seed);
            gap(6);
            for (int i = 0; i < 64; i++) op(1'b0, 2, i, 4'h0, SEL);
            a = $urandom() % 64;
            op(1'b0, 2, a, 4'h0, SEL);
            repeat (3) op(1'b1, 0, $urandom(), 4'($urandom()), SEL);
            op(1'b0, 1, a, 4'hF, SEL);
            repeat (7) op(1'b1, 0, $urandom(), 4'hF, SEL);
            gap(3);
            done("burst");
            for (int m = 0; m < 16; m++) begin
                a = $urandom() % 64;
                op(1'b0, 2, a, 4'(m), SEL);
                gap(2);
                op(1'b0, 1, a, 4'hF, SEL);
            end
            gap(3);
            done("lanes");
            for (int i = 0; i < 3; i++) begin
                a = $urandom() % 64;
                op(1'b0, 2, a, 4'h0, bad[i]);
                op(1'b1, 0, $urandom(), 4'h0, SEL);
                gap(1);
                op(1'b0, 1, a, 4'hF, SEL);
                gap(2);
            end
            done("select");
            a = $urandom() % 64;
            op(1'b0, 1, a, 4'hF, SEL);
            op(1'b1, 0, $urandom(), 4'hF, SEL);
            slw_host_model_inst.stall(3);
            op(1'b1, 0, $urandom(), 4'hF, SEL);
            slw_host_model_inst.stall(2);
            gap(2);
            op(1'b0, 2, (a + 32) % 64, 4'h0, SEL);
            slw_host_model_inst.stall(3);
            gap(3);
            op(1'b0, 1, (a + 32) % 64, 4'hF, SEL);
            gap(3);
            done("stall");
            a = $urandom() % 64;
            for (int i = 0; i < 6; i++) op(1'b0, 1 + i % 2, a + 8 * i, 4'h0, SEL);
            gap(2);
            for (int i = 1; i < 6; i += 2) op(1'b0, 1, a + 8 * i, 4'hF, SEL);
            gap(3);
            done("turnaround");
        end
        oe_n <= 1'b1;
        gap(6);
        op(1'b0, 1, 5, 4'hF, SEL);
        op(1'b1, 0, 9, 4'hF, SEL);
        gap(3);
        oe_n <= 1'b0;
        gap(6);
        done("dummy");
        // only deselects around sleep, state kept
        sleep <= 1'b1;
        for (w = 0; w < 12 && sleep_act !== 1'b1; w++) @(negedge i_clock);
        check(36'(sleep_act), 36'h1);
        @(posedge i_clock);
        sleep <= 1'b0;
        for (w = 0; w < 12 && sleep_act !== 1'b0; w++) @(negedge i_clock);
        check(36'(sleep_act), 36'h0);
        gap(2);
        op(1'b0, 1, $urandom() % 64, 4'hF, SEL);
        gap(3);
        done("sleep");
        end_sim();
    end
endmodule
